// >>> core/swm_err_counter.sv
// saturating frame error counter, six bits, limit at 32
// assumes inc and dec are one-cycle pulses from the same clock
`timescale 1ns/1ps
`default_nettype none
`include "swm_regs.svh"
module swm_err_counter (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // to the top
   swm_if.ctr cif
);
   swm_pkg::swm_cnt_t cnt_r;
   swm_pkg::swm_cnt_t cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (cif.inc && !cif.dec && cnt_r != `SWM_ECNT_LIMIT) begin
         cnt_nxt = cnt_r + 6'h01;
      end else if (cif.dec && !cif.inc && cnt_r != 6'h00) begin
         cnt_nxt = cnt_r - 6'h01;
      end
   end

   // restart keeps the low six bits, which is the whole counter
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cnt_r <= 6'h00;
      end else if (cif.restart) begin
         cnt_r <= cnt_r & `SWM_ECNT_W'(`SWM_ECNT_RESTART_KEEP);
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign cif.count = cnt_r;
   assign cif.at_limit = (cnt_r == `SWM_ECNT_LIMIT);

   dec_step_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      cif.dec && !cif.inc && !cif.restart && cnt_r != 6'h00 |=> cnt_r == $past(cnt_r) - 6'h01)
      else $error("counter did not step down on a good frame");
   no_under_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      cnt_r == 6'h00 && !cif.inc |=> cnt_r == 6'h00)
      else $error("counter went below zero");
   inc_step_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      cif.inc && !cif.dec && !cif.restart && cnt_r < 6'h20 |=> cnt_r == $past(cnt_r) + 6'h01)
      else $error("counter did not step up on a bad frame");
endmodule
`default_nettype wire

// >>> core/swm_if.sv
// signals between the monitor top and its counter and silence timer
// assumes all parties run on the one system clock
`timescale 1ns/1ps
`default_nettype none
`include "swm_regs.svh"
interface swm_if;
   logic inc;
   logic dec;
   logic restart;
   swm_pkg::swm_cnt_t count;
   logic at_limit;
   logic tmr_en;
   logic activity;
   logic silent;

   modport top (output inc, output dec, output restart, input count, input at_limit,
                output tmr_en, output activity, input silent);
   modport ctr (input inc, input dec, input restart, output count, output at_limit);
   modport tmr (input tmr_en, input activity, output silent);
endinterface
`default_nettype wire

// >>> core/swm_pkg.sv
// types shared by the selective wake status monitor modules
// assumes swm_regs.svh on the include path
`include "swm_regs.svh"
package swm_pkg;
   typedef enum logic [1:0] {
      SWM_OFF      = 2'b00,
      SWM_ON       = 2'b01,
      SWM_FALLBACK = 2'b10
   } swm_state_t;

   typedef enum logic [0:0] {
      SWM_SEL_STAT = 1'b0,
      SWM_SEL_ECNT = 1'b1
   } swm_sel_t;

   typedef logic [`SWM_ECNT_W-1:0] swm_cnt_t;
endpackage

// >>> core/swm_regs.svh
// register layout, reset values and timing figures of the selective wake status monitor
// assumes inclusion by bare name from the package and the design modules
`ifndef SWM_REGS_SVH
`define SWM_REGS_SVH

`define SWM_WORD_W 16
`define SWM_BIT_SYNC 6
`define SWM_BIT_WUP 5
`define SWM_BIT_WUF 4
`define SWM_BIT_SIL 3
`define SWM_BIT_ACT 2
`define SWM_STAT_RST 16'h0000
`define SWM_STAT_USED_MASK 16'h007c
`define SWM_STAT_RESTART_KEEP 16'h007c
`define SWM_ECNT_RST 16'h0000
`define SWM_ECNT_RESTART_KEEP 16'h003f
`define SWM_ECNT_W 6
`define SWM_ECNT_LIMIT 6'h20
`define SWM_MODE_NO_ACT 3'h4
`define SWM_MODE_CTL_BIT 2
`define SWM_CLK_KHZ 10000
`define SWM_SILENCE_TIME_US 1000
`define SWM_SILENCE_CYCLES ((`SWM_SILENCE_TIME_US * `SWM_CLK_KHZ + 999) / 1000)

`endif

// >>> core/swm_silence_timer.sv
// bus silence timer: flags when no activity was seen for the silence time
// assumes activity is a one-cycle pulse per bus edge from the bit decoder
`timescale 1ns/1ps
`default_nettype none
`include "swm_regs.svh"
module swm_silence_timer #(
   parameter int SIL_CYCLES = `SWM_SILENCE_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // to the top
   swm_if.tmr tif
);
   localparam int CW = $clog2(SIL_CYCLES + 1);
   localparam logic [CW-1:0] LIMIT = CW'(SIL_CYCLES);
   logic [CW-1:0] cnt_r;

   // the counter parks at the limit so the flag holds until the next edge
   always_ff @(posedge sys_clk) begin
      if (!rstn || !tif.tmr_en || tif.activity) begin
         cnt_r <= '0;
      end else if (cnt_r != LIMIT) begin
         cnt_r <= cnt_r + CW'(1);
      end
   end

   assign tif.silent = tif.tmr_en && (cnt_r == LIMIT);

   sil_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      tif.activity |=> !tif.silent)
      else $error("silence flag stayed after bus activity");
endmodule
`default_nettype wire

// >>> core/swm_top.sv
// selective wake status monitor: status word, error counter word, activation and fallback
// assumes the bit decoder on the same clock gives one-cycle event pulses and
// that the serial front end turns a host register read into rd_strobe with rd_sel
`timescale 1ns/1ps
`default_nettype none
`include "swm_regs.svh"
module swm_top #(
   parameter int SIL_CYCLES = `SWM_SILENCE_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic restart,
   // configuration from the control registers
   input wire logic [2:0] can_mode,
   input wire logic configuration_valid_flag,
   input wire logic system_error_clr,
   // events from the bit decoder
   input wire logic frame_ok,
   input wire logic frame_err,
   input wire logic wake_pattern_det,
   input wire logic wake_frame_match,
   input wire logic bus_activity,
   // host register read
   input wire logic rd_strobe,
   input wire swm_pkg::swm_sel_t rd_sel,
   output logic [`SWM_WORD_W-1:0] rd_data,
   // status out
   output logic system_error_flag,
   output logic selective_wake_active_flag,
   output logic wake_out
);
   swm_if sif ();

   swm_pkg::swm_state_t state_r;
   swm_pkg::swm_state_t state_nxt;
   logic [2:0] mode_prev_r;
   logic system_error_flag_r;
   logic sync_r;
   logic wup_r;
   logic wuf_r;
   logic wake_r;
   logic [`SWM_WORD_W-1:0] rd_data_r;
   logic mode_change;
   logic act;
   logic rd_stat;
   logic [`SWM_WORD_W-1:0] stat_word;
   logic [`SWM_WORD_W-1:0] ecnt_word;

   function automatic logic [`SWM_WORD_W-1:0] put_bit(input int pos, input logic v);
      logic [`SWM_WORD_W-1:0] w;
      w = '0;
      w[pos] = v;
      return w;
   endfunction

   swm_err_counter i_swm_err_counter (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .cif(sif.ctr)
   );

   swm_silence_timer #(
      .SIL_CYCLES(SIL_CYCLES)
   ) i_swm_silence_timer (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .tif(sif.tmr)
   );

   // a mode change is seen against the mode held one cycle earlier
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         mode_prev_r <= 3'h0;
      end else begin
         mode_prev_r <= can_mode;
      end
   end

   assign mode_change = (can_mode != mode_prev_r);

   // activity is the state and the three enabling conditions together
   assign act = (state_r == swm_pkg::SWM_ON) && !system_error_flag_r && configuration_valid_flag
      && can_mode[`SWM_MODE_CTL_BIT];

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         swm_pkg::SWM_OFF: begin
            if (mode_change && can_mode != `SWM_MODE_NO_ACT && !system_error_flag_r
                && configuration_valid_flag && can_mode[`SWM_MODE_CTL_BIT]) begin
               state_nxt = swm_pkg::SWM_ON;
            end
         end
         swm_pkg::SWM_ON: begin
            if (sif.at_limit) begin
               state_nxt = swm_pkg::SWM_FALLBACK;
            end else if (!act) begin
               state_nxt = swm_pkg::SWM_OFF;
            end
         end
         swm_pkg::SWM_FALLBACK: begin
            // leaves only once software has cleared the system error
            if (!system_error_flag_r) begin
               state_nxt = swm_pkg::SWM_OFF;
            end
         end
         default: begin
            state_nxt = swm_pkg::SWM_OFF;
         end
      endcase
   end

   // restart leaves the activation state alone so bit 2 survives it
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state_r <= swm_pkg::SWM_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   // system error: the limit wins over a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         system_error_flag_r <= 1'b0;
      end else if (sif.at_limit) begin
         system_error_flag_r <= 1'b1;
      end else if (system_error_clr) begin
         system_error_flag_r <= 1'b0;
      end
   end

   // counter feed: errors count only while active, good frames always count down
   assign sif.inc = frame_err && act;
   assign sif.dec = frame_ok;
   assign sif.restart = restart;
   assign sif.tmr_en = act;
   assign sif.activity = bus_activity;

   // sync needs a clean frame while active and drops as soon as activity ends
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         sync_r <= 1'b0;
      end else if (!act) begin
         sync_r <= 1'b0;
      end else if (frame_ok) begin
         sync_r <= 1'b1;
      end
   end

   assign rd_stat = rd_strobe && (rd_sel == swm_pkg::SWM_SEL_STAT);

   // clear on read, a new event in the read cycle survives it
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wup_r <= 1'b0;
      end else if (wake_pattern_det) begin
         wup_r <= 1'b1;
      end else if (rd_stat) begin
         wup_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wuf_r <= 1'b0;
      end else if (wake_frame_match && act) begin
         wuf_r <= 1'b1;
      end else if (rd_stat) begin
         wuf_r <= 1'b0;
      end
   end

   // wake on a matching frame while active, or on any pattern after fallback
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wake_r <= 1'b0;
      end else begin
         wake_r <= (act && wake_frame_match)
            || (state_r == swm_pkg::SWM_FALLBACK && wake_pattern_det);
      end
   end

   // only bits 6 to 2 are ever driven, so the reserved bits stay zero
   assign stat_word = (put_bit(`SWM_BIT_SYNC, sync_r) | put_bit(`SWM_BIT_WUP, wup_r)
      | put_bit(`SWM_BIT_WUF, wuf_r) | put_bit(`SWM_BIT_SIL, sif.silent)
      | put_bit(`SWM_BIT_ACT, act)) & `SWM_STAT_USED_MASK;
   assign ecnt_word = {{(`SWM_WORD_W-`SWM_ECNT_W){1'b0}}, sif.count};

   // read data is captured at the strobe and held until the next read;
   // restart keeps every bit that either word can hold, so a held count survives it
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rd_data_r <= `SWM_STAT_RST;
      end else if (rd_strobe) begin
         rd_data_r <= (rd_sel == swm_pkg::SWM_SEL_STAT) ? stat_word : ecnt_word;
      end else if (restart) begin
         rd_data_r <= rd_data_r & (`SWM_STAT_RESTART_KEEP | `SWM_ECNT_RESTART_KEEP);
      end
   end

   assign rd_data = rd_data_r;
   assign system_error_flag = system_error_flag_r;
   assign selective_wake_active_flag = act;
   assign wake_out = wake_r;

   rsvd_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (stat_word & ~`SWM_STAT_USED_MASK) == 16'h0000)
      else $error("reserved status bits not zero");
   sync_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      !act |=> !stat_word[`SWM_BIT_SYNC] || act)
      else $error("sync flag set while inactive");
   sync_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      act && frame_ok ##1 act |-> stat_word[`SWM_BIT_SYNC])
      else $error("sync flag missing after good frame");
   wup_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      wake_pattern_det |=> wup_r ##1 (wup_r || $past(rd_stat)))
      else $error("pattern flag lost before a read");
   wuf_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      act && wake_frame_match |=> stat_word[`SWM_BIT_WUF] && wake_out)
      else $error("wake frame not flagged");
   act_def_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      selective_wake_active_flag |-> !system_error_flag && configuration_valid_flag
         && can_mode[2])
      else $error("active flag without its conditions");
   no_act_100_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_r == swm_pkg::SWM_OFF && (can_mode == 3'h4 || !mode_change)
         |=> state_r != swm_pkg::SWM_ON)
      else $error("activated without a valid mode change");
   limit_err_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      sif.count == 6'h20 |=> system_error_flag && !selective_wake_active_flag)
      else $error("limit did not force fallback");
   fb_wake_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_r == swm_pkg::SWM_FALLBACK && wake_pattern_det |=> wake_out)
      else $error("no wake on pattern after fallback");
   rst_clear_a: assert property (@(posedge sys_clk)
      !rstn |=> rd_data == 16'h0000 && !sync_r && !wup_r && !wuf_r)
      else $error("reset left status bits set");
endmodule
`default_nettype wire

// >>> testbench/selective_wake_status_monitor_tb.sv
// self-checking bench of the selective wake status monitor against a small model
// assumes swm_top with a short silence time and the bus node model beside it
`timescale 1ns/1ps
`default_nettype none
`include "swm_regs.svh"
module selective_wake_status_monitor_tb;
   localparam int SIL = 20;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic restart = 1'b0;
   logic [2:0] can_mode = 3'h0;
   logic cfg = 1'b1;
   logic system_error_clr = 1'b0;
   logic talk = 1'b1;
   logic rd_strobe = 1'b0;
   swm_pkg::swm_sel_t rd_sel = swm_pkg::SWM_SEL_STAT;
   wire logic frame_ok;
   wire logic frame_err;
   wire logic wake_pattern_det;
   wire logic wake_frame_match;
   wire logic bus_activity;
   logic [`SWM_WORD_W-1:0] rd_data;
   logic system_error_flag;
   logic selective_wake_active_flag;
   logic wake_out;
   int fail_count = 0;
   int samples_checked = 0;
   int seed = 3;
   int cnt = 0;
   int i;
   int k;
   logic sync_m = 1'b0;
   logic wup_m = 1'b0;
   logic wuf_m = 1'b0;
   logic sil_m = 1'b0;
   logic act_m = 1'b0;

   swm_top #(.SIL_CYCLES(SIL)) i_swm_top (.sys_clk(sys_clk), .rstn(rstn), .restart(restart),
      .can_mode(can_mode), .configuration_valid_flag(cfg), .system_error_clr(system_error_clr),
      .frame_ok(frame_ok), .frame_err(frame_err), .wake_pattern_det(wake_pattern_det),
      .wake_frame_match(wake_frame_match), .bus_activity(bus_activity), .rd_strobe(rd_strobe),
      .rd_sel(rd_sel), .rd_data(rd_data), .system_error_flag(system_error_flag),
      .selective_wake_active_flag(selective_wake_active_flag), .wake_out(wake_out));
   swm_can_node i_swm_can_node (.sys_clk(sys_clk), .talk(talk), .frame_ok(frame_ok),
      .frame_err(frame_err), .wake_pattern_det(wake_pattern_det),
      .wake_frame_match(wake_frame_match), .bus_activity(bus_activity));

   always #50 sys_clk = ~sys_clk;

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   function automatic logic [15:0] stat_exp();
      return {9'h000, sync_m, wup_m, wuf_m, sil_m, act_m, 2'b00};
   endfunction

   // strobe for one cycle, then let a second edge pass so back to back reads never collide
   task automatic rd(input swm_pkg::swm_sel_t sel, input logic [15:0] exp);
      rd_sel = sel;
      rd_strobe = 1'b1;
      @(negedge sys_clk);
      rd_strobe = 1'b0;
      @(negedge sys_clk);
      check(sel == swm_pkg::SWM_SEL_STAT ? "status" : "counter", rd_data, exp);
   endtask

   task automatic end_of_test();
      if (fail_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (2) @(negedge sys_clk);
      rstn = 1'b1;
      rd(swm_pkg::SWM_SEL_STAT, stat_exp());
      rd(swm_pkg::SWM_SEL_ECNT, 16'h0000);
      can_mode = 3'h4;
      repeat (2) @(negedge sys_clk);
      check("active", {15'h0, selective_wake_active_flag}, 16'h0);
      rd(swm_pkg::SWM_SEL_STAT, stat_exp());
      can_mode = 3'h6;
      act_m = 1'b1;
      @(negedge sys_clk);
      check("active", {15'h0, selective_wake_active_flag}, 16'h1);
      cfg = 1'b0;
      #1;
      check("active", {15'h0, selective_wake_active_flag}, 16'h0);
      @(negedge sys_clk);
      cfg = 1'b1;
      // the dip ended activation; only a fresh mode change brings it back
      act_m = 1'b0;
      rd(swm_pkg::SWM_SEL_STAT, stat_exp());
      can_mode = 3'h7;
      act_m = 1'b1;
      @(negedge sys_clk);
      check("active", {15'h0, selective_wake_active_flag}, 16'h1);
      i_swm_can_node.send(0);
      sync_m = 1'b1;
      rd(swm_pkg::SWM_SEL_ECNT, 16'h0000);
      rd(swm_pkg::SWM_SEL_STAT, stat_exp());
      for (k = 2; k < 4; k++) begin
         i_swm_can_node.send(k);
         wup_m = (k == 2);
         wuf_m = (k == 3);
         rd(swm_pkg::SWM_SEL_STAT, stat_exp());
         wup_m = 1'b0;
         wuf_m = 1'b0;
         rd(swm_pkg::SWM_SEL_STAT, stat_exp());
      end
      // random mix stays below the limit: at most 24 bad frames
      for (i = 0; i < 24; i++) begin
         k = ({$random(seed)} % 4 < 3) ? 1 : 0;
         if (k == 1)
            cnt++;
         else if (cnt > 0)
            cnt--;
         i_swm_can_node.send(k);
         if (i % 4 == 3)
            rd(swm_pkg::SWM_SEL_ECNT, 16'(cnt));
      end
      i_swm_can_node.send(0);
      if (cnt > 0)
         cnt--;
      talk = 1'b0;
      repeat (SIL + 10) @(negedge sys_clk);
      sil_m = 1'b1;
      rd(swm_pkg::SWM_SEL_STAT, stat_exp());
      talk = 1'b1;
      repeat (10) @(negedge sys_clk);
      sil_m = 1'b0;
      rd(swm_pkg::SWM_SEL_STAT, stat_exp());
      i_swm_can_node.send(2);
      wup_m = 1'b1;
      restart = 1'b1;
      @(negedge sys_clk);
      restart = 1'b0;
      @(negedge sys_clk);
      rd(swm_pkg::SWM_SEL_STAT, stat_exp());
      wup_m = 1'b0;
      rd(swm_pkg::SWM_SEL_ECNT, 16'(cnt));
      while (cnt < 32) begin
         i_swm_can_node.send(1);
         cnt++;
      end
      @(negedge sys_clk);
      check("system_error_flag", {15'h0, system_error_flag}, 16'h1);
      check("active", {15'h0, selective_wake_active_flag}, 16'h0);
      rd(swm_pkg::SWM_SEL_ECNT, 16'h0020);
      check("wake", {15'h0, wake_out}, 16'h0);
      fork
         i_swm_can_node.send(2);
         begin
            @(negedge sys_clk);
            check("wake", {15'h0, wake_out}, 16'h1);
         end
      join
      // the limit keeps the error flag set until a good frame takes the count below it
      i_swm_can_node.send(0);
      cnt--;
      rd(swm_pkg::SWM_SEL_ECNT, 16'(cnt));
      system_error_clr = 1'b1;
      @(negedge sys_clk);
      system_error_clr = 1'b0;
      @(negedge sys_clk);
      check("system_error_flag", {15'h0, system_error_flag}, 16'h0);
      end_of_test();
   end

   // the sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      fail_count++;
      end_of_test();
   end
endmodule
`default_nettype wire

// >>> testbench/swm_can_node.sv
// other nodes on the shared bus: frame events, wake patterns and bus edges
// assumes the bench calls send() just after a falling edge of sys_clk
`timescale 1ns/1ps
`default_nettype none
module swm_can_node (
   // clock and idle traffic enable
   input wire logic sys_clk,
   input wire logic talk,
   // events as the bit decoder reports them
   output logic frame_ok,
   output logic frame_err,
   output logic wake_pattern_det,
   output logic wake_frame_match,
   output logic bus_activity
);
   logic [3:0] ev = 4'h0;
   logic [2:0] gap = 3'h0;
   logic tick = 1'b0;
   assign {wake_frame_match, wake_pattern_det, frame_err, frame_ok} = ev;
   // an edge every eight cycles keeps the silence timer quiet; talk low lets the bus go silent
   assign bus_activity = tick | (ev != 4'h0);
   always @(negedge sys_clk) begin
      gap <= gap + 3'h1;
      tick <= talk && (gap == 3'h0);
   end
   // kind 0 good frame, 1 bad frame, 2 wake pattern, 3 matching wake frame
   task automatic send(input int kind);
      ev = 4'h1 << kind;
      @(negedge sys_clk);
      ev = 4'h0;
      @(negedge sys_clk);
   endtask
endmodule
`default_nettype wire
